// *** inc/vtes_pkg.sv ***
// package: offsets, field layouts, reset values and carrier types
package vtes_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 7;
  localparam logic [7:0] OFF_CONTROL = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h41;
  localparam logic [7:0] OFF_VOLT_EN = 8'h7E;
  localparam logic [7:0] OFF_TEMP_EN = 8'h82;
  localparam logic [7:0] OFF_LIMIT_BASE = 8'hA0;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_VOLT_EN = 8'h00;
  localparam logic [7:0] RST_TEMP_EN = 8'h00;
  localparam logic [7:0] RST_LOW_LIMIT = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT = 8'hFF;
  localparam int BIT_START = 0;
  localparam int BIT_PENDING = 7;
  localparam int BIT_V25 = 0;
  localparam int BIT_VCORE = 1;
  localparam int BIT_V33 = 2;
  localparam int BIT_V5 = 3;
  localparam int BIT_DIODE_A = 4;
  localparam int BIT_INTERNAL = 5;
  localparam int BIT_DIODE_B = 6;
  localparam int VOLT_EN_LSB = 0;
  localparam int TEMP_EN_LSB = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } vtes_bus_s;

  typedef struct packed {
    logic [NUM_CH-1:0] valid;
    logic [NUM_CH-1:0][7:0] value;
  } vtes_conv_s;
endpackage : vtes_pkg

// *** src/vtes_event_status.sv ***
// voltage and temperature sticky event status register with its enables
`timescale 1ns/1ps
`default_nettype none
module vtes_event_status #(
  parameter int NUM_CH = vtes_pkg::NUM_CH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire vtes_pkg::vtes_bus_s busIn,
  output logic [vtes_pkg::DATA_W-1:0] readData,
  input wire vtes_pkg::vtes_conv_s convIn,
  input wire logic secondStatusAny,
  input wire logic globalIrqAllow,
  output logic monitorStart,
  output logic [7:0] eventStatus
);

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] statusReg;
  logic [7:0] controlReg;
  logic [7:0] voltEnReg;
  logic [7:0] tempEnReg;
  logic [NUM_CH-1:0][7:0] lowLimit;
  logic [NUM_CH-1:0][7:0] highLimit;
  logic [NUM_CH-1:0] activeViol;
  logic [NUM_CH-1:0][7:0] lastReading;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic wrControl;
  wire logic wrVoltEn;
  wire logic wrTempEn;
  wire logic rdStatus;
  wire logic inLimitSpace;
  wire logic [7:0] limitOffset;
  wire logic [3:0] limitIdx;
  wire logic limitHigh;
  wire logic limitIdxOk;

  assign wrControl = busIn.wr && busIn.addr == vtes_pkg::OFF_CONTROL;
  assign wrVoltEn = busIn.wr && busIn.addr == vtes_pkg::OFF_VOLT_EN;
  assign wrTempEn = busIn.wr && busIn.addr == vtes_pkg::OFF_TEMP_EN;
  assign rdStatus = busIn.rd && busIn.addr == vtes_pkg::OFF_STATUS;
  // limits sit in pairs (low, high) per channel, channel order = bit order
  assign limitOffset = busIn.addr - vtes_pkg::OFF_LIMIT_BASE;
  assign inLimitSpace = busIn.addr >= vtes_pkg::OFF_LIMIT_BASE;
  assign limitIdx = limitOffset[4:1];
  assign limitHigh = limitOffset[0];
  assign limitIdxOk = inLimitSpace && limitOffset < 8'(2 * NUM_CH);

  ////////////////////////////////////////////////////////////////////////
  // per channel enables and evaluation
  wire logic start;
  wire logic [NUM_CH-1:0] chEnable;
  wire logic [NUM_CH-1:0] chUpdate;
  wire logic [NUM_CH-1:0] chViol;
  wire logic [NUM_CH-1:0] next_bits;
  wire logic [NUM_CH-1:0] next_active;

  assign start = controlReg[vtes_pkg::BIT_START];
  assign chEnable[vtes_pkg::BIT_V25] = voltEnReg[vtes_pkg::VOLT_EN_LSB];
  assign chEnable[vtes_pkg::BIT_VCORE] = voltEnReg[vtes_pkg::VOLT_EN_LSB+1];
  assign chEnable[vtes_pkg::BIT_V33] = voltEnReg[vtes_pkg::VOLT_EN_LSB+2];
  assign chEnable[vtes_pkg::BIT_V5] = voltEnReg[vtes_pkg::VOLT_EN_LSB+3];
  assign chEnable[vtes_pkg::BIT_DIODE_A] = tempEnReg[vtes_pkg::TEMP_EN_LSB];
  assign chEnable[vtes_pkg::BIT_INTERNAL] =
    tempEnReg[vtes_pkg::TEMP_EN_LSB+1];
  assign chEnable[vtes_pkg::BIT_DIODE_B] = tempEnReg[vtes_pkg::TEMP_EN_LSB+2];

  // global allow is taken in but deliberately steers nothing here
  wire logic unusedAllow;
  assign unusedAllow = globalIrqAllow;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      // results landing while stopped are dropped
      assign chUpdate[g] = convIn.valid[g] && start;
      // each channel compares against its own pair of limits
      assign chViol[g] = (convIn.value[g] <= lowLimit[g]) ||
                         (convIn.value[g] > highLimit[g]);
      assign next_active[g] = chUpdate[g] ? chViol[g] : activeViol[g];
      // update: set if enabled and violating; a disabled bit drops here
      // read: clears only if the channel is currently quiet
      // a set arriving with the read wins over the clear
      assign next_bits[g] =
        chUpdate[g] ? (chEnable[g] ? ((statusReg[g] &&
                         !(rdStatus && !activeViol[g])) || chViol[g])
                                   : 1'b0)
                    : (statusReg[g] && !(rdStatus && !activeViol[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register writes and status update
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      statusReg <= vtes_pkg::RST_STATUS;
      controlReg <= vtes_pkg::RST_CONTROL;
      voltEnReg <= vtes_pkg::RST_VOLT_EN;
      tempEnReg <= vtes_pkg::RST_TEMP_EN;
      activeViol <= '0;
    end else begin
      // status writes fall through the decode and are dropped
      statusReg[NUM_CH-1:0] <= next_bits;
      // summary bit mirrors the second register directly
      statusReg[vtes_pkg::BIT_PENDING] <= secondStatusAny;
      activeViol <= next_active;
      if (wrControl) begin
        controlReg <= {7'h00, busIn.wdata[vtes_pkg::BIT_START]};
      end
      if (wrVoltEn) begin
        voltEnReg <= busIn.wdata;
      end
      if (wrTempEn) begin
        tempEnReg <= busIn.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lowLimit <= {NUM_CH{vtes_pkg::RST_LOW_LIMIT}};
      highLimit <= {NUM_CH{vtes_pkg::RST_HIGH_LIMIT}};
      lastReading <= '0;
    end else begin
      if (busIn.wr && limitIdxOk) begin
        if (limitHigh) begin
          highLimit[limitIdx] <= busIn.wdata;
        end else begin
          lowLimit[limitIdx] <= busIn.wdata;
        end
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (chUpdate[i]) begin
          lastReading[i] <= convIn.value[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, data valid the cycle after the strobe
  wire logic [7:0] next_readData;
  wire logic [7:0] limitRead;
  assign limitRead = limitHigh ? highLimit[limitIdx] : lowLimit[limitIdx];
  assign next_readData =
    !busIn.rd ? 8'h00 :
    busIn.addr == vtes_pkg::OFF_STATUS ? statusReg :
    busIn.addr == vtes_pkg::OFF_CONTROL ? controlReg :
    busIn.addr == vtes_pkg::OFF_VOLT_EN ? voltEnReg :
    busIn.addr == vtes_pkg::OFF_TEMP_EN ? tempEnReg :
    limitIdxOk ? limitRead : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      readData <= 8'h00;
      monitorStart <= 1'b0;
      eventStatus <= vtes_pkg::RST_STATUS;
    end else begin
      readData <= next_readData;
      // track the control bit in the same cycle it is written
      monitorStart <= wrControl ? busIn.wdata[vtes_pkg::BIT_START] : start;
      // bit 7 shown with the same timing as the stored summary bit
      eventStatus <= {secondStatusAny, next_bits};
    end
  end

  wire logic unusedReading;
  assign unusedReading = ^lastReading;

endmodule : vtes_event_status
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the event status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ST = vtes_pkg::OFF_STATUS;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  vtes_pkg::vtes_bus_s busIn = '0;
  vtes_pkg::vtes_conv_s convIn = '0;
  logic secondStatusAny = 1'b0;
  logic globalIrqAllow = 1'b1;
  logic [7:0] readData;
  logic [7:0] eventStatus;
  logic monitorStart;
  int num_errors = 0;
  int n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  vtes_event_status dut (.clk_sys, .rst_b, .busIn, .readData, .convIn,
    .secondStatusAny, .globalIrqAllow, .monitorStart, .eventStatus);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // strobe drops and an idle edge passes, so calls never collide
  task automatic wr(input logic [7:0] a, d);
    busIn.addr <= a;
    busIn.wdata <= d;
    busIn.wr <= 1'b1;
    @(posedge clk_sys);
    busIn.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    busIn.addr <= a;
    busIn.rd <= 1'b1;
    @(posedge clk_sys);
    busIn.rd <= 1'b0;
    #1;
    chk("readData", exp, readData);
    @(posedge clk_sys);
  endtask : rd
  task automatic conv(input int ch, input logic [7:0] v);
    convIn.value[ch] <= v;
    convIn.valid[ch] <= 1'b1;
    @(posedge clk_sys);
    convIn.valid <= '0;
    @(posedge clk_sys);
  endtask : conv
  task automatic st(input logic [7:0] exp);
    #1;
    chk("eventStatus", exp, eventStatus);
  endtask : st
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ST, 8'h00);
    rd(8'h3F, 8'h00);
    chk("monitorStart", 8'h00, {7'h00, monitorStart});
    $display("reset test done");
  endtask : t_reset
  task automatic t_set();
    wr(vtes_pkg::OFF_CONTROL, 8'h01);
    wr(vtes_pkg::OFF_VOLT_EN, 8'h0F);
    wr(vtes_pkg::OFF_TEMP_EN, 8'h07);
    for (int i = 0; i < 7; i++) begin
      conv(i, 8'h00);
    end
    rd(ST, 8'h7F);
    rd(ST, 8'h7F);
    globalIrqAllow <= 1'b0;
    wr(ST, 8'hFF);
    st(8'h7F);
    // equal to the high limit is still inside the window
    for (int i = 0; i < 7; i++) begin
      conv(i, 8'hFF);
    end
    rd(ST, 8'h7F);
    rd(ST, 8'h00);
    $display("set and clear test done");
  endtask : t_set
  task automatic t_enable();
    wr(vtes_pkg::OFF_VOLT_EN, 8'h00);
    conv(0, 8'h00);
    st(8'h00);
    conv(4, 8'h00);
    st(8'h10);
    wr(vtes_pkg::OFF_TEMP_EN, 8'h00);
    wr(vtes_pkg::OFF_CONTROL, 8'h00);
    conv(4, 8'h00);
    st(8'h10);
    wr(vtes_pkg::OFF_CONTROL, 8'h01);
    conv(4, 8'h00);
    st(8'h00);
    $display("enable test done");
  endtask : t_enable
  task automatic t_limit();
    wr(8'hA1, 8'h80);
    rd(8'hA1, 8'h80);
    wr(vtes_pkg::OFF_VOLT_EN, 8'h01);
    conv(0, 8'h81);
    rd(ST, 8'h01);
    conv(0, 8'h80);
    rd(ST, 8'h01);
    rd(ST, 8'h00);
    $display("limit test done");
  endtask : t_limit
  task automatic t_pend();
    secondStatusAny <= 1'b1;
    @(posedge clk_sys);
    rd(ST, 8'h80);
    rd(ST, 8'h80);
    secondStatusAny <= 1'b0;
    repeat (2) @(posedge clk_sys);
    st(8'h00);
    $display("pending test done");
  endtask : t_pend
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_set();
    t_enable();
    t_limit();
    t_pend();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// *** testbench/vtes_event_status_asserts.sv ***
// port checker for the event status block
`timescale 1ns/1ps
`default_nettype none
module vtes_event_status_chk #(
  parameter int NUM_CH = vtes_pkg::NUM_CH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire vtes_pkg::vtes_bus_s busIn,
  input wire logic [vtes_pkg::DATA_W-1:0] readData,
  input wire vtes_pkg::vtes_conv_s convIn,
  input wire logic secondStatusAny,
  input wire logic monitorStart,
  input wire logic [7:0] eventStatus
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_read_data: assert property (busIn.rd && busIn.addr == 8'h41
    |=> readData == $past(eventStatus)) else $error("read data wrong");
  chk_read_idle: assert property (!busIn.rd |=> readData == 8'h00)
    else $error("read data outside read");
  chk_pend_set: assert property (secondStatusAny |=> eventStatus[7])
    else $error("pending bit not set");
  chk_pend_clear: assert property (!secondStatusAny |=> !eventStatus[7])
    else $error("pending bit not cleared");
  chk_quiet_hold: assert property (!(|convIn.valid) && !busIn.rd
    |=> $stable(eventStatus[NUM_CH-1:0])) else $error("status moved");
  chk_rise_cause: assert property (1'b1 |=> (eventStatus[NUM_CH-1:0]
    & ~$past(eventStatus[NUM_CH-1:0]) & ~$past(convIn.valid)) == 0)
    else $error("status rose without result");
  chk_stop_no_set: assert property (!monitorStart |=>
    (eventStatus[NUM_CH-1:0] & ~$past(eventStatus[NUM_CH-1:0])) == 0)
    else $error("status rose while stopped");
  chk_start_copy: assert property (busIn.wr && busIn.addr == 8'h40
    |=> monitorStart == $past(busIn.wdata[0])) else $error("start wrong");
endmodule : vtes_event_status_chk
////////////////////////////////////////////////////////////////////////////
bind vtes_event_status vtes_event_status_chk #(.NUM_CH(NUM_CH)) u_chk (
  .clk_sys, .rst_b, .busIn, .readData, .convIn, .secondStatusAny,
  .monitorStart, .eventStatus);
`default_nettype wire
